/* verilog/txstat_pkg.sv */
// Constants for the transmit descriptor status write-back block.
// Assumes one clock, aclk at 20 MHz, and a synchronous active-low reset.
package txstat_pkg;
	// Register byte offsets
	localparam logic [3:0]  OFS_CONFIG     = 4'h0;
	localparam logic [3:0]  OFS_CONTROL    = 4'h4;
	localparam logic [3:0]  OFS_STATE      = 4'h8;
	localparam logic [3:0]  OFS_LAST_WORD0 = 4'hc;
	localparam logic [31:0] CONFIG_RESET   = 32'h0000_0000;
	// Configuration and control bit positions
	localparam int CFG_ENHANCED   = 0;
	localparam int CFG_OVER_WAIT  = 4;
	localparam int CFG_RETRY_DIS  = 9;
	localparam int CFG_FULL_DUP   = 11;
	localparam int CFG_JABBER_DIS = 22;
	localparam int CTL_RESUME     = 0;
	// Status field positions in descriptor word zero, and the last-segment bit of desc_ctrl
	localparam int B_CARRIER_WAIT = 0;
	localparam int B_UNDERFLOW    = 1;
	localparam int B_OVER_WAIT    = 2;
	localparam int B_CCOUNT_LO    = 3;
	localparam int B_VLAN         = 7;
	localparam int B_EXC_COLL     = 8;
	localparam int B_LATE_COLL    = 9;
	localparam int B_NO_CARRIER   = 10;
	localparam int B_CARRIER_LOST = 11;
	localparam int B_PAYLOAD_ERR  = 12;
	localparam int B_FLUSHED      = 13;
	localparam int B_JABBER       = 14;
	localparam int B_ERR_SUMMARY  = 15;
	localparam int B_HEADER_ERR   = 16;
	localparam int B_TS_CAPTURED  = 17;
	localparam int CTRL_LAST_SEG  = 9;
	// Collision limit, word indexes and response codes
	localparam logic [3:0]  COLL_LIMIT     = 4'hf;
	localparam logic [2:0]  W_STATUS       = 3'h0;
	localparam logic [2:0]  W_TS_LO        = 3'h2;
	localparam logic [2:0]  W_TS_HI        = 3'h3;
	localparam logic [2:0]  W_TS_LO_ENH    = 3'h6;
	localparam logic [2:0]  W_TS_HI_ENH    = 3'h7;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_DECERR    = 2'h3;
	// Write-back sequencer states
	typedef enum logic [3:0] {
		WB_IDLE  = 4'b0001,
		WB_TS_LO = 4'b0010,
		WB_TS_HI = 4'b0100,
		WB_WORD0 = 4'b1000
	} wb_state_e;
endpackage : txstat_pkg

/* verilog/collision_tally.sv */
// Per-frame collision counter with excessive-collision abort.
// Assumes collision pulses arrive from MAC logic on aclk.
`timescale 1ns/1ps
`default_nettype none
module collision_tally
	import txstat_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       clear,
	input  wire logic       collision,
	input  wire logic       retry_disable,
	output var  logic [3:0] count,
	output var  logic       excessive
);
	wire hit_limit = collision & (retry_disable | (count == COLL_LIMIT));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count     <= 4'h0;
			excessive <= 1'b0;
		end else if (clear) begin
			count     <= {3'h0, collision};
			excessive <= collision & retry_disable;
		end else begin
			if (collision && count != COLL_LIMIT)
				count <= count + 4'h1;
			if (hit_limit)
				excessive <= 1'b1;
		end
	end
endmodule : collision_tally
`default_nettype wire

/* verilog/eth_tx_descriptor_status.sv */
// Status write-back for transmit descriptor word zero, with AXI4-Lite registers.
// Assumes MAC events are one-cycle pulses on aclk; carrier sense is an async pin.
`timescale 1ns/1ps
`default_nettype none
module eth_tx_descriptor_status
	import txstat_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        awvalid,
	output var  logic        awready,
	input  wire logic [31:0] awaddr,
	input  wire logic        wvalid,
	output var  logic        wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output var  logic        bvalid,
	input  wire logic        bready,
	output var  logic [1:0]  bresp,
	input  wire logic        arvalid,
	output var  logic        arready,
	input  wire logic [31:0] araddr,
	output var  logic        rvalid,
	input  wire logic        rready,
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	input  wire logic        carrier_sense,
	input  wire logic        frame_start,
	input  wire logic        frame_end,
	input  wire logic [10:0] desc_ctrl,
	input  wire logic        carrier_wait_flag,
	input  wire logic        underflow_error,
	input  wire logic        over_wait_flag,
	input  wire logic        collision,
	input  wire logic        vlan_tagged_flag,
	input  wire logic        late_collision,
	input  wire logic        payload_check_error,
	input  wire logic        header_check_error,
	input  wire logic        frame_flushed,
	input  wire logic        jabber_timeout,
	input  wire logic        ts_capture,
	input  wire logic [63:0] ts_value,
	output var  logic        abort_frame,
	output var  logic        tx_suspended,
	output var  logic        wb_valid,
	input  wire logic        wb_ready,
	output var  logic [2:0]  wb_index,
	output var  logic [31:0] wb_data
);
	logic [31:0] mac_config_reg;
	logic [31:0] last_word0;
	logic [31:0] word0;
	logic [63:0] ts_hold;
	logic        crs_meta;
	logic        crs_sync;
	logic        in_frame;
	logic        seen_carrier;
	logic        f_wait, f_under, f_over, f_vlan, f_late;
	logic        f_lost, f_pay, f_head, f_flush, f_jab, f_ts, f_coll;
	logic        aw_held, w_held;
	logic [3:0]  aw_ofs;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	wb_state_e   state;
	logic [3:0]  coll_count;
	logic        coll_excess;

	// Configuration decode
	wire half_duplex  = ~mac_config_reg[CFG_FULL_DUP];
	wire enhanced     = mac_config_reg[CFG_ENHANCED];
	wire last_seg     = desc_ctrl[CTRL_LAST_SEG];
	wire frame_clear  = frame_start;

	collision_tally u_tally (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.clear         (frame_clear),
		.collision     (collision & in_frame),
		.retry_disable (mac_config_reg[CFG_RETRY_DIS]),
		.count         (coll_count),
		.excessive     (coll_excess)
	);

	// Carrier sense synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crs_meta <= 1'b0;
			crs_sync <= 1'b0;
		end else begin
			crs_meta <= carrier_sense;
			crs_sync <= crs_meta;
		end
	end

	// Per-frame sticky flags; a new event wins over the frame-start clear
	wire keep = ~frame_clear;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_frame     <= 1'b0;
			seen_carrier <= 1'b0;
			{f_wait, f_under, f_over, f_vlan, f_late} <= 5'h00;
			{f_lost, f_pay, f_head, f_flush, f_jab, f_ts, f_coll} <= 7'h00;
		end else begin
			in_frame     <= frame_start | (in_frame & ~frame_end);
			seen_carrier <= (keep & seen_carrier) | (in_frame & crs_sync);
			f_wait  <= (keep & f_wait) | (carrier_wait_flag & half_duplex);
			f_under <= (keep & f_under) | underflow_error;
			f_over  <= (keep & f_over) | (over_wait_flag & mac_config_reg[CFG_OVER_WAIT]);
			f_vlan  <= (keep & f_vlan) | vlan_tagged_flag;
			f_late  <= (keep & f_late) | late_collision;
			f_lost  <= (keep & f_lost) | (in_frame & seen_carrier & ~crs_sync & half_duplex);
			f_coll  <= (keep & f_coll) | collision;
			f_pay   <= (keep & f_pay) | payload_check_error;
			f_head  <= (keep & f_head) | header_check_error;
			f_flush <= (keep & f_flush) | frame_flushed;
			f_jab   <= (keep & f_jab) | (jabber_timeout & ~mac_config_reg[CFG_JABBER_DIS]);
			f_ts    <= (keep & f_ts) | ts_capture;
		end
	end

	// Word zero assembly
	logic [19:0] stat;
	always_comb begin
		stat = 20'h0_0000;
		stat[B_CARRIER_WAIT] = f_wait;
		stat[B_UNDERFLOW]    = f_under;
		stat[B_OVER_WAIT]    = f_over;
		stat[B_CCOUNT_LO +: 4] = coll_count;
		stat[B_VLAN]         = f_vlan;
		stat[B_EXC_COLL]     = coll_excess;
		stat[B_LATE_COLL]    = f_late;
		stat[B_NO_CARRIER]   = ~seen_carrier & ~crs_sync;
		stat[B_CARRIER_LOST] = f_lost & ~f_coll;
		stat[B_PAYLOAD_ERR]  = f_pay;
		stat[B_FLUSHED]      = f_flush;
		stat[B_JABBER]       = f_jab;
		stat[B_HEADER_ERR]   = f_head;
		stat[B_TS_CAPTURED]  = f_ts & last_seg;
		stat[B_ERR_SUMMARY]  = stat[B_UNDERFLOW] | stat[B_OVER_WAIT] | stat[B_EXC_COLL]
			| stat[B_LATE_COLL] | stat[B_NO_CARRIER] | stat[B_CARRIER_LOST]
			| stat[B_PAYLOAD_ERR] | stat[B_FLUSHED] | stat[B_JABBER] | stat[B_HEADER_ERR];
	end
	wire [19:0] stat_out   = last_seg ? stat : 20'h0_0000;
	wire [31:0] next_word0 = {1'b0, desc_ctrl, stat_out};
	wire        take_frame = frame_end & state[0];
	wire        wb_fire    = wb_valid & wb_ready;
	wire        ts_write   = next_word0[B_TS_CAPTURED];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state    <= WB_IDLE;
			wb_valid <= 1'b0;
			wb_index <= W_STATUS;
			wb_data  <= 32'h0000_0000;
			word0    <= 32'h0000_0000;
			ts_hold  <= 64'h0000_0000_0000_0000;
		end else begin
			unique case (state)
				WB_IDLE: if (take_frame) begin
					word0    <= next_word0;
					ts_hold  <= ts_value;
					wb_valid <= 1'b1;
					if (ts_write) begin
						state    <= WB_TS_LO;
						wb_index <= enhanced ? W_TS_LO_ENH : W_TS_LO;
						wb_data  <= ts_value[31:0];
					end else begin
						state    <= WB_WORD0;
						wb_index <= W_STATUS;
						wb_data  <= next_word0;
					end
				end
				WB_TS_LO: if (wb_fire) begin
					state    <= WB_TS_HI;
					wb_index <= enhanced ? W_TS_HI_ENH : W_TS_HI;
					wb_data  <= ts_hold[63:32];
				end
				WB_TS_HI: if (wb_fire) begin
					state    <= WB_WORD0;
					wb_index <= W_STATUS;
					wb_data  <= word0;
				end
				WB_WORD0: if (wb_fire) begin
					state    <= WB_IDLE;
					wb_valid <= 1'b0;
				end
			endcase
		end
	end

	// AXI4-Lite slave
	wire ar_fire  = arvalid & arready;
	wire wr_go    = aw_held & w_held & ~bvalid;
	wire hit_cfg  = aw_ofs == OFS_CONFIG;
	wire hit_ctl  = aw_ofs == OFS_CONTROL;
	wire wr_ok    = hit_cfg | hit_ctl | (aw_ofs == OFS_STATE) | (aw_ofs == OFS_LAST_WORD0);
	wire resume   = wr_go & hit_ctl & w_strb[0] & w_data[CTL_RESUME];
	wire [3:0] r_ofs = araddr[3:0];
	wire rd_ok    = araddr[31:4] == 28'h000_0000;
	wire [31:0] rd_mux = !rd_ok ? 32'h0000_0000 :
		(r_ofs == OFS_CONFIG)     ? mac_config_reg :
		(r_ofs == OFS_STATE)      ? {30'h0000_0000, wb_valid, tx_suspended} :
		(r_ofs == OFS_LAST_WORD0) ? last_word0 : 32'h0000_0000;
	wire rd_hit   = rd_ok & (r_ofs == OFS_CONFIG || r_ofs == OFS_CONTROL
		|| r_ofs == OFS_STATE || r_ofs == OFS_LAST_WORD0);
	logic [31:0] cfg_masked;
	always_comb begin
		cfg_masked = mac_config_reg;
		for (int i = 0; i < 4; i++)
			if (w_strb[i])
				cfg_masked[i*8 +: 8] = w_data[i*8 +: 8];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_ofs  <= 4'h0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			mac_config_reg <= CONFIG_RESET;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_held <= 1'b1;
				aw_ofs  <= (awaddr[31:4] == 28'h000_0000) ? awaddr[3:0] : 4'h3;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp  <= wr_ok ? RESP_OKAY : RESP_DECERR;
				if (hit_cfg)
					mac_config_reg <= cfg_masked;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end else if (ar_fire) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_mux;
			rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Abort, suspend and status mirror
	wire word0_done = state[3] & wb_fire;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			abort_frame  <= 1'b0;
			tx_suspended <= 1'b0;
			last_word0   <= 32'h0000_0000;
		end else begin
			abort_frame  <= in_frame & collision
				& (mac_config_reg[CFG_RETRY_DIS] | ((coll_count == COLL_LIMIT) & ~frame_clear));
			tx_suspended <= (word0_done & word0[B_UNDERFLOW]) | (tx_suspended & ~resume);
			if (word0_done)
				last_word0 <= word0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	reserved_zero_a: assert property (wb_valid && wb_index == W_STATUS |-> wb_data[19:18] == 2'h0)
		else $error("Reserved bits written nonzero");
	own_cleared_a: assert property (wb_valid && wb_index == W_STATUS |-> !wb_data[31])
		else $error("Ownership bit not cleared");
	err_summary_a: assert property (wb_valid && wb_index == W_STATUS
		|-> wb_data[B_ERR_SUMMARY] == |{wb_data[14:8], wb_data[2:1], wb_data[B_HEADER_ERR]})
		else $error("Error summary mismatch");
	nonlast_clean_a: assert property (wb_valid && wb_index == W_STATUS && !wb_data[29]
		|-> wb_data[19:0] == 20'h0_0000)
		else $error("Status in non-last descriptor");
	suspend_set_a: assert property (state[3] && wb_fire && word0[B_UNDERFLOW] |=> tx_suspended)
		else $error("Underflow did not suspend");
	over_wait_gate_a: assert property (wb_valid && wb_index == W_STATUS && wb_data[B_OVER_WAIT]
		|-> mac_config_reg[CFG_OVER_WAIT])
		else $error("Excessive deferral with gate off");
	jabber_gate_a: assert property (jabber_timeout && mac_config_reg[CFG_JABBER_DIS] && !frame_start
		|=> f_jab == $past(f_jab))
		else $error("Jabber flagged while disabled");
	retry_abort_a: assert property (in_frame && collision && mac_config_reg[CFG_RETRY_DIS]
		|=> abort_frame && coll_excess)
		else $error("Retry disable did not abort");
	ts_order_a: assert property (state[1] && wb_fire |=> wb_valid && state[2] ##1 !state[1])
		else $error("Timestamp words out of order");
	wb_hold_a: assert property (wb_valid && !wb_ready |=> $stable(wb_data) && $stable(wb_index) && wb_valid)
		else $error("Write-back payload changed while waiting");

	ts_path_c: cover property (take_frame && ts_write ##[1:40] word0_done);
	under_c: cover property (word0_done && word0[B_UNDERFLOW] ##1 tx_suspended);
	excess_c: cover property (coll_excess && frame_end);
	axi_write_c: cover property (bvalid && bready && bresp == RESP_OKAY);
endmodule : eth_tx_descriptor_status
`default_nettype wire

/* testbench/desc_mem_model.sv */
// Descriptor memory model that takes the status write-back words.
// Assumes one word is offered at a time; stall sets the wait before ready.
`timescale 1ns/1ps
`default_nettype none
module desc_mem_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        wb_valid,
	input  wire logic [2:0]  wb_index,
	input  wire logic [31:0] wb_data,
	input  wire logic [3:0]  stall,
	output var  logic        wb_ready
);
	logic [31:0] mem [8];
	logic [8:0]  idx_hist;
	logic [3:0]  wait_cnt;
	int          n_writes;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wb_ready <= 1'b0;
			wait_cnt <= 4'h0;
			n_writes <= 0;
			idx_hist <= 9'h000;
		end else if (wb_valid && wb_ready) begin
			mem[wb_index] <= wb_data;
			idx_hist      <= {idx_hist[5:0], wb_index};
			n_writes      <= n_writes + 1;
			wb_ready      <= 1'b0;
			wait_cnt      <= 4'h0;
		end else if (wb_valid && wait_cnt >= stall) begin
			wb_ready <= 1'b1;
		end else if (wb_valid) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule : desc_mem_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the descriptor status write-back block.
// Assumes the package, the block and the memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import txstat_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, wb_valid, wb_ready, abort_frame, tx_suspended;
	logic        carrier_sense, frame_start, frame_end, collision;
	logic [31:0] awaddr, wdata, araddr, rdata, wb_data, rd;
	logic [1:0]  bresp, rresp, resp;
	logic [3:0]  wstrb, stall;
	logic [2:0]  wb_index;
	logic [10:0] desc_ctrl;
	logic [17:0] ev_q;
	logic [63:0] ts_value;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          n_abort = 0;
	int          err_bits [9] = '{1, 2, 9, 10, 11, 12, 13, 14, 16};

	eth_tx_descriptor_status DUT (
		.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
		.bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.carrier_sense, .frame_start, .frame_end, .desc_ctrl, .collision, .ts_value,
		.carrier_wait_flag(ev_q[0]), .underflow_error(ev_q[1]), .over_wait_flag(ev_q[2]),
		.vlan_tagged_flag(ev_q[7]), .late_collision(ev_q[9]), .payload_check_error(ev_q[12]),
		.frame_flushed(ev_q[13]), .jabber_timeout(ev_q[14]), .header_check_error(ev_q[16]),
		.ts_capture(ev_q[17]), .abort_frame, .tx_suspended, .wb_valid, .wb_ready, .wb_index, .wb_data
	);
	desc_mem_model mm (.aclk, .aresetn, .wb_valid, .wb_index, .wb_data, .stall, .wb_ready);

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (abort_frame === 1'b1) n_abort <= n_abort + 1;
	end

	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk_word
	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		chk_word({30'h0, g}, {30'h0, e});
	endtask : chk_resp
	task automatic chk_bit(input logic g, input logic e);
		chk_word({31'h0, g}, {31'h0, e});
	endtask : chk_bit
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	task automatic timed_out();
		n_mismatch++;
		$display("wrong value at %0t: wait ran out", $time);
		give_verdict();
	endtask : timed_out

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		int   t;
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		for (t = 0; t < 100 && !(ad && dd); t++) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				dd = 1'b1;
			end
		end
		if (!(ad && dd)) timed_out();
		bready <= 1'b1;
		for (t = 0; t < 100; t++) begin
			@(posedge aclk);
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (t == 100) timed_out();
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		araddr  <= a;
		arvalid <= 1'b1;
		for (t = 0; t < 100; t++) begin
			@(posedge aclk);
			if (arready) break;
		end
		if (t == 100) timed_out();
		arvalid <= 1'b0;
		rready  <= 1'b1;
		for (t = 0; t < 100; t++) begin
			@(posedge aclk);
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (t == 100) timed_out();
	endtask : axi_rd

	// One frame: ev bit 10 keeps carrier away, bit 11 drops it mid-frame
	task automatic frame(input logic [31:0] cfg, input logic [17:0] ev, input int nc,
			input logic [10:0] ctrl, input logic [17:0] st);
		int          t, n0, a0, k;
		logic [31:0] e, m;
		logic [2:0]  lo;
		carrier_sense <= !ev[10];
		axi_wr(32'(OFS_CONFIG), cfg, resp);
		n0 = mm.n_writes;
		a0 = n_abort;
		k  = ev[17] ? 3 : 1;
		stall       <= ev[17] ? 4'h5 : 4'h0;
		frame_start <= 1'b1;
		@(posedge aclk);
		frame_start <= 1'b0;
		ev_q        <= ev;
		@(posedge aclk);
		ev_q        <= 18'h0_0000;
		repeat (nc) begin
			collision <= 1'b1;
			@(posedge aclk);
			collision <= 1'b0;
			@(posedge aclk);
		end
		repeat (4) @(posedge aclk);
		if (ev[11]) carrier_sense <= 1'b0;
		repeat (4) @(posedge aclk);
		desc_ctrl <= ctrl;
		frame_end <= 1'b1;
		@(posedge aclk);
		frame_end <= 1'b0;
		repeat (2) @(posedge aclk);
		frame_end <= ev[17];
		@(posedge aclk);
		frame_end <= 1'b0;
		for (t = 0; t < 200 && mm.n_writes != n0 + k; t++) @(posedge aclk);
		if (t == 200) timed_out();
		repeat (10) @(posedge aclk);
		e      = {1'b0, ctrl, 2'b00, st};
		e[6:3] = (nc > 15) ? 4'hf : 4'(nc);
		e[15]  = |(st & 18'h1_7f06);
		if (!ctrl[9]) e[19:0] = 20'h0_0000;
		m  = st[8] ? 32'hffff_ff87 : 32'hffff_ffff;
		lo = cfg[0] ? W_TS_LO_ENH : W_TS_LO;
		chk_word(mm.mem[0] & m, e & m);
		axi_rd(32'(OFS_LAST_WORD0), rd, resp);
		chk_word(rd & m, e & m);
		chk_word(32'(mm.n_writes - n0), 32'(k));
		chk_word(32'(n_abort - a0), {31'h0, st[8]});
		if (ev[17]) begin
			chk_word(mm.mem[lo], ts_value[31:0]);
			chk_word(mm.mem[lo + 3'h1], ts_value[63:32]);
			chk_word({23'h0, mm.idx_hist}, {23'h0, lo, lo + 3'h1, W_STATUS});
		end
	endtask : frame

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{frame_start, frame_end, collision} = 3'h0;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb         = 4'hf;
		stall         = 4'h0;
		carrier_sense = 1'b1;
		desc_ctrl     = 11'h000;
		ev_q          = 18'h0_0000;
		ts_value      = 64'h0123_4567_89ab_cdef;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(32'(OFS_CONFIG), rd, resp);
		chk_word(rd, CONFIG_RESET);
		axi_wr(32'(OFS_CONFIG), 32'h0040_0a11, resp);
		chk_resp(resp, RESP_OKAY);
		axi_rd(32'(OFS_CONFIG), rd, resp);
		chk_word(rd, 32'h0040_0a11);
		wstrb <= 4'h1;
		axi_wr(32'(OFS_CONFIG), 32'hffff_ffff, resp);
		wstrb <= 4'hf;
		axi_rd(32'(OFS_CONFIG), rd, resp);
		chk_word(rd, 32'h0040_0aff);
		axi_rd(32'(OFS_CONTROL), rd, resp);
		chk_word(rd, 32'h0000_0000);
		chk_resp(resp, RESP_OKAY);
		axi_rd(32'h0000_0010, rd, resp);
		chk_resp(resp, RESP_DECERR);
		chk_word(rd, 32'h0000_0000);
		axi_wr(32'h0000_0020, 32'h0000_0001, resp);
		chk_resp(resp, RESP_DECERR);
		frame(32'h0000_0000, 18'h0_0081, 3, 11'h6a5, 18'h0_0081);
		foreach (err_bits[i]) frame(32'h0000_0010, 18'h0_0001 << err_bits[i], 0, 11'h200,
			18'h0_0001 << err_bits[i]);
		chk_bit(tx_suspended, 1'b1);
		axi_rd(32'(OFS_STATE), rd, resp);
		chk_bit(rd[0], 1'b1);
		axi_wr(32'(OFS_CONTROL), 32'h0000_0001, resp);
		chk_resp(resp, RESP_OKAY);
		axi_rd(32'(OFS_STATE), rd, resp);
		chk_bit(rd[0], 1'b0);
		chk_bit(rd[1], 1'b0);
		frame(32'h0000_0000, 18'h0_0004, 0, 11'h200, 18'h0_0000);
		frame(32'h0040_0000, 18'h0_4000, 0, 11'h200, 18'h0_0000);
		frame(32'h0000_0000, 18'h0_0000, 16, 11'h200, 18'h0_0100);
		frame(32'h0000_0200, 18'h0_0000, 1, 11'h200, 18'h0_0100);
		frame(32'h0000_0800, 18'h0_0001, 0, 11'h200, 18'h0_0000);
		frame(32'h0000_0000, 18'h0_0800, 2, 11'h200, 18'h0_0000);
		frame(32'h0000_0000, 18'h0_1200, 0, 11'h1a5, 18'h0_0000);
		frame(32'h0000_0000, 18'h2_0000, 0, 11'h200, 18'h2_0000);
		frame(32'h0000_0001, 18'h2_0000, 0, 11'h200, 18'h2_0000);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
